// [rtl/pss_pkg.sv]
// package: register map, fields, reset values and codes of the set sequencer
package pss_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TOTAL = 8'h04;
  localparam logic [7:0] OFS_INDEX = 8'h08;
  localparam logic [7:0] OFS_ACTIVE = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_ADV_LSB = 2;
  localparam int CTRL_RST_LSB = 4;
  localparam int CTRL_SWAP_BIT = 6;
  localparam int CTRL_INV1_BIT = 7;
  localparam int CTRL_INV2_BIT = 8;
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int CMD_STEP_BIT = 2;
  localparam int CMD_REWIND_BIT = 3;
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_FRAME_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_IDX_LSB = 8;

  // ****************************************
  // counts and reset values
  // ****************************************
  localparam int MAX_ORDERED = 64;
  localparam int MAX_FREE = 4;
  localparam int PARAM_W = 32;
  localparam logic [6:0] TOTAL_RST = 7'h02;
  localparam logic [31:0] DEFAULT_SET = 32'h0000_0000;

  // control sources and states
  typedef enum logic [1:0] {
    SRC_ALWAYS = 2'b00,
    SRC_LINE1 = 2'b01,
    SRC_LINE2 = 2'b10,
    SRC_OFF = 2'b11
  } pss_src_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_APPLY = 2'b10,
    ST_EXPOSE = 2'b11
  } pss_state_type;

endpackage

// [rtl/pss_sync.sv]
// three-flop input synchroniser with agreement filter and change flag
`timescale 1ns/1ps
module pss_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] moving_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W < 1) begin : g_bad_param
    $error("pss_sync: W must be at least 1");
  end

  // ****************************************
  // per-bit chain
  // ****************************************
  for (genvar b = 0; b < W; b++) begin : g_bit
    // s1 feeds s2 only; level moves once s2 and s3 agree
    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        s1_q[b] <= 1'b0;
        s2_q[b] <= 1'b0;
        s3_q[b] <= 1'b0;
        level_o[b] <= 1'b0;
        moving_o[b] <= 1'b0;
      end else begin
        s1_q[b] <= async_i[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        moving_o[b] <= (s2_q[b] != s3_q[b]) || (s3_q[b] != level_o[b]);
        if (s2_q[b] == s3_q[b]) begin
          level_o[b] <= s3_q[b];
        end
      end
    end
  end

endmodule // pss_sync

// [rtl/pss_mem.sv]
// stored parameter sets, one write port and a registered read port
`timescale 1ns/1ps
module pss_mem #(
  parameter int DEPTH = 64,
  parameter int W = 32
) (
  input wire logic clk_sys_i,
  input wire logic [$clog2(DEPTH)-1:0] addr_i,
  input wire logic we_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] rdata_o
);

  logic [W-1:0] mem_q [DEPTH];

  if (DEPTH < 2 || W < 1) begin : g_bad_param
    $error("pss_mem: DEPTH must be 2 or more and W 1 or more");
  end

  // read data always from a register, one cycle after the address
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule // pss_mem

// [rtl/pss_seq.sv]
// parameter set sequencer: register slave, ordered and free selection
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module pss_seq #(
  parameter int N_SETS = pss_pkg::MAX_ORDERED,
  parameter int PW = pss_pkg::PARAM_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic frame_start_i,
  input wire logic line1_i,
  input wire logic line2_i,
  input wire logic frame_done_i,
  output logic waiting_o,
  output logic frame_active_o,
  output logic seq_running_o,
  output logic [$clog2(N_SETS)-1:0] cur_index_o,
  output logic [PW-1:0] active_set_o
);

  localparam int IW = $clog2(N_SETS);
  localparam int TW = IW + 1;

  if (N_SETS < pss_pkg::MAX_FREE || N_SETS > pss_pkg::MAX_ORDERED ||
      PW < 1 || PW > 32) begin : g_bad_param
    $error("pss_seq: N_SETS must be 4..64 and PW 1..32");
  end

  // ****************************************
  // declarations
  // ****************************************
  pss_pkg::pss_state_type state_q;
  pss_pkg::pss_src_type adv_src_q;
  pss_pkg::pss_src_type rst_src_q;
  logic on_q, mode_q, swap_q, inv1_q, inv2_q, run_q, exp_after_q, fv_q;
  logic [TW-1:0] total_q;
  logic [IW-1:0] index_q, mem_addr_q, fetch_addr, next_idx, free_addr;
  logic [PW-1:0] saved_q, mem_rdata;
  logic [N_SETS-1:0] valid_q;
  logic store_pend_q, load_pend_q, step_pend_q, rewind_pend_q;
  logic mem_we_q, trig_prev_q;
  logic [2:0] pin_level, pin_moving;
  logic acc, wr_acc, lvl1, lvl2, b0, b1, line_busy, trig_rise, trig_acc;
  logic adv_hit, rst_hit, do_store, do_enable, do_disable, do_fetch;
  logic go_expose, take_load, take_rewind, take_step;
  logic [31:0] wd;

  // ****************************************
  // pin synchronisers and stored sets
  // ****************************************
  pss_sync #(.W(3)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({line2_i, line1_i, frame_start_i}),
    .level_o(pin_level),
    .moving_o(pin_moving)
  );

  pss_mem #(.DEPTH(N_SETS), .W(PW)) u_mem (
    .clk_sys_i(clk_sys_i),
    .addr_i(mem_addr_q),
    .we_i(mem_we_q),
    .wdata_i(active_set_o),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // line decode and trigger qualification
  // ****************************************
  assign lvl1 = pin_level[1] ^ inv1_q;
  assign lvl2 = pin_level[2] ^ inv2_q;
  // line 1 on bit 0 unless software swapped the lines
  assign b0 = swap_q ? lvl2 : lvl1;
  assign b1 = swap_q ? lvl1 : lvl2;
  // the bit 1 line only counts when more than two sets are in use
  assign free_addr = (total_q > TW'(2)) ? IW'({b1, b0}) : IW'(b0);
  assign line_busy = pin_moving[1] | pin_moving[2];
  assign trig_rise = pin_level[0] & ~trig_prev_q;
  // a trigger outside the waiting window is simply dropped
  assign trig_acc = trig_rise & waiting_o & ~line_busy &
                    (state_q == pss_pkg::ST_IDLE);
  assign adv_hit = (adv_src_q == pss_pkg::SRC_ALWAYS) ||
                   (adv_src_q == pss_pkg::SRC_LINE1 && lvl1) ||
                   (adv_src_q == pss_pkg::SRC_LINE2 && lvl2);
  assign rst_hit = (rst_src_q == pss_pkg::SRC_LINE1 && lvl1) ||
                   (rst_src_q == pss_pkg::SRC_LINE2 && lvl2);
  // wrap after the last configured set
  assign next_idx = ({1'b0, cur_index_o} == total_q - TW'(1)) ?
                    '0 : cur_index_o + IW'(1);

  // ****************************************
  // bus slave: one wait cycle per access
  // ****************************************
  assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign wr_acc = acc & avs_write_i;
  assign wd = avs_writedata_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  // read data latched in the wait cycle, stands at the accept edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      unique case (avs_address_i)
        pss_pkg::OFS_CTRL:
          avs_readdata_o <= 32'({inv2_q, inv1_q, swap_q, rst_src_q,
                                 adv_src_q, mode_q, on_q});
        pss_pkg::OFS_TOTAL: avs_readdata_o <= 32'(total_q);
        pss_pkg::OFS_INDEX: avs_readdata_o <= 32'(index_q);
        pss_pkg::OFS_ACTIVE: avs_readdata_o <= 32'(active_set_o);
        pss_pkg::OFS_STATUS:
          avs_readdata_o <= 32'(cur_index_o) << pss_pkg::STAT_IDX_LSB |
                            32'({run_q, frame_active_o, waiting_o});
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // configuration fields; only the enable may change while running
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      on_q <= 1'b0;
      mode_q <= 1'b0;
      adv_src_q <= pss_pkg::SRC_OFF;
      rst_src_q <= pss_pkg::SRC_OFF;
      swap_q <= 1'b0;
      inv1_q <= 1'b0;
      inv2_q <= 1'b0;
    end else if (wr_acc && avs_address_i == pss_pkg::OFS_CTRL) begin
      on_q <= wd[pss_pkg::CTRL_ON_BIT];
      if (!on_q && !run_q) begin
        mode_q <= wd[pss_pkg::CTRL_MODE_BIT];
        adv_src_q <= pss_pkg::pss_src_type'(wd[pss_pkg::CTRL_ADV_LSB +: 2]);
        // always-active is not a restart choice: it reads as off
        rst_src_q <= (wd[pss_pkg::CTRL_RST_LSB +: 2] == 2'b00) ?
          pss_pkg::SRC_OFF :
          pss_pkg::pss_src_type'(wd[pss_pkg::CTRL_RST_LSB +: 2]);
        swap_q <= wd[pss_pkg::CTRL_SWAP_BIT];
        inv1_q <= wd[pss_pkg::CTRL_INV1_BIT];
        inv2_q <= wd[pss_pkg::CTRL_INV2_BIT];
      end
    end
  end

  // set count: out-of-range writes are ignored, free mode clamps to four
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      total_q <= TW'(pss_pkg::TOTAL_RST);
    end else if (wr_acc && !on_q && !run_q) begin
      if (avs_address_i == pss_pkg::OFS_TOTAL && wd != 32'h0000_0000 &&
          wd <= (mode_q ? 32'(pss_pkg::MAX_FREE) : 32'(N_SETS))) begin
        total_q <= TW'(wd);
      end else if (avs_address_i == pss_pkg::OFS_CTRL &&
                   wd[pss_pkg::CTRL_MODE_BIT] &&
                   total_q > TW'(pss_pkg::MAX_FREE)) begin
        total_q <= TW'(pss_pkg::MAX_FREE);
      end
    end
  end

  // set index, values past the last set are ignored
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      index_q <= '0;
    end else if (wr_acc && avs_address_i == pss_pkg::OFS_INDEX &&
                 wd < 32'(N_SETS)) begin
      index_q <= IW'(wd);
    end
  end

  // ****************************************
  // command and trigger-sampled pending flags
  // ****************************************
  // a new request in the cycle that consumes the old one survives
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      store_pend_q <= 1'b0;
      load_pend_q <= 1'b0;
      step_pend_q <= 1'b0;
      rewind_pend_q <= 1'b0;
    end else begin
      store_pend_q <= (store_pend_q & ~do_store) |
        (wr_acc && avs_address_i == pss_pkg::OFS_CMD &&
         wd[pss_pkg::CMD_STORE_BIT]);
      load_pend_q <= (load_pend_q & ~take_load) |
        (wr_acc && avs_address_i == pss_pkg::OFS_CMD &&
         wd[pss_pkg::CMD_LOAD_BIT]);
      step_pend_q <= (step_pend_q & ~take_step) |
        (wr_acc && avs_address_i == pss_pkg::OFS_CMD &&
         wd[pss_pkg::CMD_STEP_BIT]) |
        (trig_acc & run_q & ~mode_q & adv_hit);
      rewind_pend_q <= (rewind_pend_q & ~take_rewind) |
        (wr_acc && avs_address_i == pss_pkg::OFS_CMD &&
         wd[pss_pkg::CMD_REWIND_BIT]) |
        (trig_acc & run_q & ~mode_q & rst_hit);
    end
  end

  // ****************************************
  // idle-state decision, one action per cycle
  // ****************************************
  always_comb begin
    do_store = 1'b0;
    do_enable = 1'b0;
    do_disable = 1'b0;
    do_fetch = 1'b0;
    go_expose = 1'b0;
    take_load = 1'b0;
    take_rewind = 1'b0;
    take_step = 1'b0;
    fetch_addr = '0;
    if (state_q == pss_pkg::ST_IDLE) begin
      if (trig_acc) begin
        // free mode picks the set from the lines at the trigger
        do_fetch = run_q & mode_q;
        go_expose = ~(run_q & mode_q);
        fetch_addr = free_addr;
      end else if (store_pend_q) begin
        do_store = 1'b1;
      end else if (on_q && !run_q) begin
        do_enable = 1'b1;
        do_fetch = ~mode_q;
      end else if (!on_q && run_q) begin
        do_disable = 1'b1;
      end else if (load_pend_q) begin
        take_load = 1'b1;
        do_fetch = 1'b1;
        fetch_addr = index_q;
      end else if (rewind_pend_q) begin
        take_rewind = 1'b1;
        do_fetch = run_q & ~mode_q;
      end else if (step_pend_q) begin
        take_step = 1'b1;
        do_fetch = run_q & ~mode_q;
        fetch_addr = next_idx;
      end
    end
  end

  // ****************************************
  // sequencing state
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q <= pss_pkg::ST_IDLE;
      exp_after_q <= 1'b0;
    end else begin
      unique case (state_q)
        pss_pkg::ST_IDLE: begin
          exp_after_q <= trig_acc;
          if (do_fetch) begin
            state_q <= pss_pkg::ST_FETCH;
          end else if (go_expose) begin
            state_q <= pss_pkg::ST_EXPOSE;
          end
        end
        pss_pkg::ST_FETCH: state_q <= pss_pkg::ST_APPLY;
        pss_pkg::ST_APPLY: begin
          state_q <= exp_after_q ? pss_pkg::ST_EXPOSE : pss_pkg::ST_IDLE;
        end
        // a disable waits here until the frame is out
        pss_pkg::ST_EXPOSE: begin
          if (frame_done_i) begin
            state_q <= pss_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // memory port, current index and fetched-entry validity
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mem_addr_q <= '0;
      mem_we_q <= 1'b0;
      cur_index_o <= '0;
      fv_q <= 1'b0;
    end else begin
      mem_we_q <= do_store;
      if (do_store) begin
        mem_addr_q <= index_q;
      end else if (do_fetch) begin
        mem_addr_q <= fetch_addr;
        cur_index_o <= fetch_addr;
        fv_q <= valid_q[fetch_addr];
      end
    end
  end

  // one stored flag per set, set by its first store
  for (genvar e = 0; e < N_SETS; e++) begin : g_valid
    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        valid_q[e] <= 1'b0;
      end else if (do_store && index_q == IW'(e)) begin
        valid_q[e] <= 1'b1;
      end
    end
  end

  // active values: fetch, restore on disable, or a direct write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      active_set_o <= PW'(pss_pkg::DEFAULT_SET);
      saved_q <= PW'(pss_pkg::DEFAULT_SET);
      run_q <= 1'b0;
    end else begin
      if (state_q == pss_pkg::ST_APPLY) begin
        // unstored sets come out as defaults, not stale memory
        active_set_o <= fv_q ? mem_rdata :
                        PW'(pss_pkg::DEFAULT_SET);
      end else if (do_disable) begin
        active_set_o <= saved_q;
      end else if (wr_acc && avs_address_i == pss_pkg::OFS_ACTIVE &&
                   state_q == pss_pkg::ST_IDLE) begin
        active_set_o <= PW'(wd);
      end
      if (do_enable) begin
        saved_q <= active_set_o;
        run_q <= 1'b1;
      end else if (do_disable) begin
        run_q <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      waiting_o <= 1'b0;
      frame_active_o <= 1'b0;
      seq_running_o <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= pin_level[0];
      // leaves waiting while lines move, an action starts, or a store or load is queued
      waiting_o <= (state_q == pss_pkg::ST_IDLE) && !line_busy &&
                   !do_fetch && !go_expose && !do_store && !do_enable &&
                   !do_disable && !store_pend_q && !load_pend_q;
      frame_active_o <= (state_q == pss_pkg::ST_EXPOSE && !frame_done_i) ||
                        go_expose || (state_q == pss_pkg::ST_APPLY &&
                        exp_after_q);
      seq_running_o <= run_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_total_bound: assert property (
    total_q >= TW'(1) && total_q <= TW'(N_SETS))
    else $error("set count out of range");
  chk_free_limit: assert property (
    mode_q |-> total_q <= TW'(pss_pkg::MAX_FREE))
    else $error("free mode set count above four");
  chk_trig_ignore: assert property (
    trig_rise && line_busy |=> state_q != pss_pkg::ST_EXPOSE &&
    !exp_after_q)
    else $error("trigger taken while a line moved");
  chk_free_fetch: assert property (
    trig_acc && run_q && mode_q |=> state_q == pss_pkg::ST_FETCH
    ##1 state_q == pss_pkg::ST_APPLY ##1 state_q == pss_pkg::ST_EXPOSE)
    else $error("free trigger did not fetch then expose");
  chk_free_addr: assert property (
    trig_acc && run_q && mode_q |=> cur_index_o == $past(free_addr))
    else $error("free mode picked the wrong set");
  chk_enable_zero: assert property (
    do_enable && !mode_q |=> mem_addr_q == '0 && cur_index_o == '0)
    else $error("enable did not select set zero");
  chk_wrap_zero: assert property (
    take_step && run_q && !mode_q &&
    {1'b0, cur_index_o} == total_q - TW'(1) |=> cur_index_o == '0)
    else $error("last set did not wrap to zero");
  chk_store_write: assert property (
    do_store |=> mem_we_q && mem_addr_q == $past(index_q))
    else $error("store did not write the indexed set");
  chk_load_apply: assert property (
    state_q == pss_pkg::ST_APPLY && fv_q |=> active_set_o == $past(mem_rdata))
    else $error("fetched set not applied");
  chk_restore_val: assert property (
    do_disable |=> active_set_o == $past(saved_q) && !run_q)
    else $error("active values not restored on disable");
  chk_step_always: assert property (
    trig_acc && run_q && !mode_q && adv_src_q == pss_pkg::SRC_ALWAYS
    |=> step_pend_q)
    else $error("always source did not step");

  cov_free_trig: cover property (trig_acc && run_q && mode_q);
  cov_wrap: cover property (take_step && run_q && next_idx == '0);
  cov_restore: cover property (do_disable);
  cov_store: cover property (do_store);
  cov_drop: cover property (trig_rise && line_busy);

endmodule // pss_seq

// [testbench/pss_ext_model.sv]
// partner model: frame trigger source and input line drivers
`timescale 1ns/1ps
module pss_ext_model (
  input wire logic clk_sys_i,
  input wire logic waiting_i,
  input wire logic frame_active_i,
  output logic frame_start_o,
  output logic line1_o,
  output logic line2_o,
  output logic frame_done_o,
  output logic miss_o
);
  int n;
  // all lines quiet at time zero
  initial begin
    {frame_start_o, line1_o, line2_o, frame_done_o, miss_o} = 5'h00;
  end
  // ****************************************
  // line levels, then settle before any trigger
  // ****************************************
  task set_lines(input logic l1, input logic l2);
    @(posedge clk_sys_i);
    line1_o <= l1;
    line2_o <= l2;
    repeat (10) @(posedge clk_sys_i); // sync chain must go quiet first
  endtask
  // one frame; hold sets how slowly the frame is finished
  task shoot(input int hold);
    n = 0;
    while (waiting_i !== 1'b1 && n < 60) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 60) miss_o <= 1'b1;
    frame_start_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (frame_active_i !== 1'b1 && n < 60);
    if (n >= 60) miss_o <= 1'b1;
    frame_start_o <= 1'b0;
    repeat (hold) @(posedge clk_sys_i);
    frame_done_o <= 1'b1;
    @(posedge clk_sys_i);
    frame_done_o <= 1'b0;
  endtask
  // trigger together with a line change: the device must drop it
  task rush(input logic l1, input logic l2, output logic seen);
    @(posedge clk_sys_i);
    line1_o <= l1;
    line2_o <= l2;
    frame_start_o <= 1'b1;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk_sys_i);
      seen = seen | frame_active_i;
    end
    frame_start_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule // pss_ext_model

// [testbench/pss_seq_test.sv]
// self-checking bench of the parameter set sequencer
`timescale 1ns/1ps
module pss_seq_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat, act, q;
  logic wreq, fs, l1, l2, fd, waiting, fact, run, miss, seen_f;
  logic [5:0] idx;
  int err_total = 0;
  int num_checks = 0;
  int k;

  always #5 clk_sys = ~clk_sys;

  pss_seq i_dut (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .frame_start_i(fs),
    .line1_i(l1), .line2_i(l2), .frame_done_i(fd), .waiting_o(waiting),
    .frame_active_o(fact), .seq_running_o(run), .cur_index_o(idx),
    .active_set_o(act));
  pss_ext_model i_ext (.clk_sys_i(clk_sys), .waiting_i(waiting),
    .frame_active_i(fact), .frame_start_o(fs), .line1_o(l1), .line2_o(l2),
    .frame_done_o(fd), .miss_o(miss));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] sv(input int n);
    return 32'hA5A5_0000 + n;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk_sys);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  // let a load finish, then wait for waiting; the watchdog bounds it
  task settle;
    repeat (8) @(posedge clk_sys);
    while (waiting !== 1'b1) begin
      @(posedge clk_sys);
    end
  endtask
  task frame(input logic a, input logic b, input int n);
    i_ext.set_lines(a, b);
    i_ext.shoot(4);
    settle();
    check({26'h0, idx}, n);
    check(act, sv(n));
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // watchdog: whole run needs far fewer cycles
  // ****************************************
  initial begin
    #500_000;
    err_total++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(pss_pkg::OFS_TOTAL, {25'h0, pss_pkg::TOTAL_RST});
    rd_chk(8'h18, 32'h0000_0000);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0040);
    rd_chk(pss_pkg::OFS_TOTAL, 32'h0000_0040);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0041);
    rd_chk(pss_pkg::OFS_TOTAL, 32'h0000_0040);
    bus(1'b1, pss_pkg::OFS_INDEX, 32'h0000_003F);
    bus(1'b1, pss_pkg::OFS_INDEX, 32'h0000_0040);
    rd_chk(pss_pkg::OFS_INDEX, 32'h0000_003F);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, pss_pkg::OFS_INDEX, k);
      bus(1'b1, pss_pkg::OFS_ACTIVE, sv(k));
      bus(1'b1, pss_pkg::OFS_CMD, 32'h0000_0001);
    end
    bus(1'b1, pss_pkg::OFS_INDEX, 32'h0000_0002);
    bus(1'b1, pss_pkg::OFS_CMD, 32'h0000_0002);
    settle();
    check(act, sv(2));
    bus(1'b1, pss_pkg::OFS_INDEX, 32'h0000_0009);
    bus(1'b1, pss_pkg::OFS_CMD, 32'h0000_0002);
    settle();
    check(act, pss_pkg::DEFAULT_SET);
    // ordered run, advance on every trigger, restart off
    bus(1'b1, pss_pkg::OFS_ACTIVE, 32'h0000_0077);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0003);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0031);
    settle();
    check(act, sv(0));
    check({29'h0, run, fact, waiting}, 32'h0000_0005);
    rd_chk(pss_pkg::OFS_STATUS, 32'h0000_0005);
    frame(1'b0, 1'b0, 1);
    frame(1'b0, 1'b0, 2);
    frame(1'b0, 1'b0, 0);
    bus(1'b1, pss_pkg::OFS_CMD, 32'h0000_0004);
    settle();
    check(act, sv(1));
    bus(1'b1, pss_pkg::OFS_CMD, 32'h0000_0008);
    settle();
    check(act, sv(0));
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0030);
    settle();
    check(act, 32'h0000_0077);
    check({29'h0, run, fact, waiting}, 32'h0000_0001);
    rd_chk(pss_pkg::OFS_STATUS, 32'h0000_0001);
    rd_chk(pss_pkg::OFS_ACTIVE, 32'h0000_0077);
    // ordered run, advance on line 1, restart on line 2
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0024);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0025);
    settle();
    frame(1'b0, 1'b0, 0);
    frame(1'b1, 1'b0, 1);
    frame(1'b0, 1'b1, 0);
    // free selection, line 1 on bit 0 and line 2 on bit 1
    // first write only disables; fields change once stopped
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0002);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0002);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0005);
    rd_chk(pss_pkg::OFS_TOTAL, 32'h0000_0003);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0004);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0003);
    frame(1'b1, 1'b0, 1);
    frame(1'b0, 1'b0, 0);
    frame(1'b0, 1'b1, 2);
    frame(1'b1, 1'b1, 3);
    // trigger while both lines move is dropped, set 3 stays
    i_ext.rush(1'b0, 1'b0, seen_f);
    check({31'h0, seen_f}, 32'h0000_0000);
    check({26'h0, idx}, 32'h0000_0003);
    check(act, sv(3));
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0082);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0083);
    frame(1'b1, 1'b0, 0);
    frame(1'b0, 1'b0, 1);
    // swapped lines, line 2 inverted
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0142);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0143);
    frame(1'b1, 1'b1, 2);
    frame(1'b0, 1'b0, 1);
    // two sets: only the bit 0 line counts
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0002);
    bus(1'b1, pss_pkg::OFS_TOTAL, 32'h0000_0002);
    bus(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0003);
    rd_chk(pss_pkg::OFS_CTRL, 32'h0000_0033);
    frame(1'b0, 1'b1, 0);
    frame(1'b1, 1'b1, 1);
    check({31'h0, miss}, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // pss_seq_test
